// ==== rtl/iom_pkg.sv ====
/*
 * Package for the increment / OR / move execute block: opcode patterns,
 * field positions, widths and reset values.
 * Assumes 14-bit instruction words and an 8-bit data path.
 */
package iom_pkg;
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int FILE_DEPTH = 128;
    // Six-bit major opcode field sits in bits 13:8.
    localparam int OPC_MSB = 13;
    localparam int OPC_LSB = 8;
    localparam int DEST_BIT = 7;
    localparam int ADDR_MSB = 6;
    localparam int LIT_MSB = 7;
    localparam logic [5:0] OPC_INCREMENT_FILE = 6'h0a;
    localparam logic [5:0] OPC_OR_LITERAL_INTO_ACC = 6'h38;
    localparam logic [5:0] OPC_OR_ACC_WITH_FILE = 6'h04;
    localparam logic [5:0] OPC_MOVE_FILE = 6'h08;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;
    localparam logic [7:0] ONE = 8'h01;

    typedef enum logic [3:0] {
        IOM_OP_NONE = 4'b0001,
        IOM_OP_INC = 4'b0010,
        IOM_OP_OR = 4'b0100,
        IOM_OP_MOVE = 4'b1000
    } iom_op_t;
endpackage : iom_pkg

// ==== rtl/iom_file_ram.sv ====
/*
 * File register memory: one combinational-address read port with a
 * registered output and one write port.
 * Assumes the read address is presented one cycle before the data is used.
 */
`timescale 1ns/1ps
module iom_file_ram #(
    parameter int DEPTH = 128,
    parameter int AW = 7,
    parameter int DW = 8
) (
    input wire logic ref_clk_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [DW-1:0] rd_data_o,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [DW-1:0] wr_data_i
);
    logic [DW-1:0] mem [DEPTH];

    // Elaboration check: a depth beyond the address range leaves words unreachable.
    if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
        $error("DEPTH must lie between 1 and the address range");
    end

    // Write-first, so a read of the word being written returns the new value.
    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        if (wr_en_i && (wr_addr_i == rd_addr_i)) begin
            rd_data_o <= wr_data_i;
        end else begin
            rd_data_o <= mem[rd_addr_i];
        end
    end
endmodule : iom_file_ram

// ==== rtl/iom_exec.sv ====
/*
 * Decode and execute stage for four instructions of an 8-bit accumulator
 * core: file increment, literal OR, accumulator-file OR and file move.
 * Each accepted word updates the accumulator or one file word, the zero
 * flag, a one-cycle done pulse and a one-hot class code, all registered.
 * Words with any other opcode, or without instr_valid_i, leave the accumulator, file and zero flag alone, drop done and set the class to IOM_OP_NONE.
 * Assumes fetch logic presents one instruction word per cycle with
 * instr_valid_i, and that the file memory read is issued by this block
 * from the fetch-side address one cycle earlier (instr_next_i).
 * Assumes instr_next_i, instr_valid_i and instr_i come from logic on the
 * same clock, so no synchroniser stands in front of them.
 */
`timescale 1ns/1ps
module iom_exec
    import iom_pkg::*;
#(
    parameter int FILE_WORDS = iom_pkg::FILE_DEPTH
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [iom_pkg::INSTR_W-1:0] instr_next_i,
    input wire logic instr_valid_i,
    input wire logic [iom_pkg::INSTR_W-1:0] instr_i,
    output logic [iom_pkg::DATA_W-1:0] acc_o,
    output logic zero_o,
    output logic done_o,
    output logic [3:0] op_o
);
    import iom_pkg::*;

    // Elaboration checks: the field slices below follow the package layout, so a
    // package edit that moves a field is refused here instead of miswiring decode.
    // A FILE_WORDS below the depth leaves the upper addresses reading as unknown.
    if (FILE_WORDS < 1 || FILE_WORDS > FILE_DEPTH) begin : g_bad_words
        $error("FILE_WORDS must lie between 1 and FILE_DEPTH");
    end
    if (FILE_DEPTH > (1 << ADDR_W)) begin : g_bad_depth
        $error("FILE_DEPTH exceeds the file address range");
    end
    if (OPC_MSB != INSTR_W - 1 || OPC_MSB - OPC_LSB != 5) begin : g_bad_opc
        $error("opcode field must be the top six instruction bits");
    end
    if (DEST_BIT != OPC_LSB - 1 || ADDR_MSB != ADDR_W - 1) begin : g_bad_addr
        $error("destination and address fields do not match the address width");
    end
    if (DEST_BIT != ADDR_W) begin : g_bad_dest
        $error("destination bit must sit just above the file address");
    end
    if (LIT_MSB != DATA_W - 1 || LIT_MSB >= OPC_LSB) begin : g_bad_lit
        $error("literal field must fill the bits below the opcode");
    end
    if (OPC_INCREMENT_FILE == OPC_OR_ACC_WITH_FILE || OPC_INCREMENT_FILE == OPC_MOVE_FILE
            || OPC_OR_ACC_WITH_FILE == OPC_MOVE_FILE) begin : g_bad_codes
        $error("file-form opcodes must be distinct");
    end
    if (OPC_OR_LITERAL_INTO_ACC == OPC_INCREMENT_FILE
            || OPC_OR_LITERAL_INTO_ACC == OPC_MOVE_FILE
            || OPC_OR_LITERAL_INTO_ACC == OPC_OR_ACC_WITH_FILE) begin : g_bad_lit_code
        $error("literal opcode must differ from the file-form opcodes");
    end

    typedef struct packed {
        logic [DATA_W-1:0] acc;
        logic zero;
        logic done;
        iom_op_t op;
    } iom_state_t;

    iom_state_t state;
    iom_state_t next_state;

    // Instruction fields.
    logic [5:0] opc;
    logic dest;
    logic [ADDR_W-1:0] faddr;
    logic [DATA_W-1:0] lit;

    // Decode results.
    iom_op_t dec_op;
    logic lit_form;
    logic to_file;
    logic to_acc;

    // Operands and result.
    logic [DATA_W-1:0] file_q;
    logic [DATA_W-1:0] or_operand;
    logic [DATA_W-1:0] result;
    logic result_zero;
    logic affects;
    logic file_we;

    assign opc = instr_i[OPC_MSB:OPC_LSB];
    assign dest = instr_i[DEST_BIT];
    assign faddr = instr_i[ADDR_MSB:0];
    assign lit = instr_i[LIT_MSB:0];

    // The read is issued from the next word so its registered data lines up with
    // the word being executed. Write-first forwarding covers a back-to-back
    // instruction that reads the file word the previous one has just written.
    iom_file_ram #(
        .DEPTH(FILE_WORDS),
        .AW(ADDR_W),
        .DW(DATA_W)
    ) u_ram (
        .ref_clk_i(ref_clk_i),
        .rd_addr_i(instr_next_i[ADDR_MSB:0]),
        .rd_data_o(file_q),
        .wr_en_i(file_we),
        .wr_addr_i(faddr),
        .wr_data_i(result)
    );

    always_comb begin
        dec_op = IOM_OP_NONE;
        lit_form = 1'b0;
        if (instr_valid_i) begin
            case (opc)
                OPC_INCREMENT_FILE: begin
                    dec_op = IOM_OP_INC;
                end
                OPC_OR_LITERAL_INTO_ACC: begin
                    dec_op = IOM_OP_OR;
                    lit_form = 1'b1;
                end
                OPC_OR_ACC_WITH_FILE: begin
                    dec_op = IOM_OP_OR;
                end
                OPC_MOVE_FILE: begin
                    dec_op = IOM_OP_MOVE;
                end
                default: begin
                    dec_op = IOM_OP_NONE;
                end
            endcase
        end
    end

    always_comb begin
        result = state.acc;
        affects = 1'b0;
        or_operand = lit_form ? lit : file_q;
        case (dec_op)
            IOM_OP_INC: begin
                result = DATA_W'(file_q + ONE);
                affects = 1'b1;
            end
            IOM_OP_OR: begin
                result = state.acc | or_operand;
                affects = 1'b1;
            end
            IOM_OP_MOVE: begin
                result = file_q;
                affects = 1'b1;
            end
            IOM_OP_NONE: begin
                affects = 1'b0;
            end
            default: begin
                affects = 1'b0;
            end
        endcase
    end

    assign result_zero = (result == '0);

    // The literal form has no destination bit: bit 7 belongs to the literal, so it
    // must never reach the file write enable.
    // destination select
    always_comb begin
        to_file = affects && dest && !lit_form;
        to_acc = affects && !to_file;
        file_we = to_file;
    end

    always_comb begin
        next_state = state;
        next_state.done = affects;
        next_state.op = dec_op;
        if (to_acc) begin
            next_state.acc = result;
        end
        if (affects) begin
            next_state.zero = result_zero;
        end
    end

    // Only the outputs are reset; file words keep whatever they held, so a
    // program must write a file word before it relies on its value.
    // single cycle execute
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= '{acc: ACC_RESET, zero: ZERO_RESET, done: 1'b0, op: IOM_OP_NONE};
        end else begin
            state <= next_state;
        end
    end

    // Outputs come straight from the state flip-flops.
    assign acc_o = state.acc;
    assign zero_o = state.zero;
    assign done_o = state.done;
    assign op_o = state.op;
endmodule : iom_exec

// ==== tb/iom_exec_checker.sv ====
/* Port assertions for the execute block. Assumes one clock, async active-low reset. */
`timescale 1ns/1ps
module iom_exec_checker #(
    parameter int FILE_WORDS = 128
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [13:0] instr_next_i,
    input wire logic instr_valid_i,
    input wire logic [13:0] instr_i,
    input wire logic [7:0] acc_o,
    input wire logic zero_o,
    input wire logic done_o,
    input wire logic [3:0] op_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire [5:0] opc = instr_i[13:8];
    wire go = instr_valid_i && opc inside {6'h0a, 6'h38, 6'h04, 6'h08};
    wire fd = instr_i[7] && opc != 6'h38;
    chk_lit_or: assert property (go && opc == 6'h38
        |=> acc_o == ($past(acc_o) | $past(instr_i[7:0]))) else $error("literal OR wrong");
    chk_file_dest: assert property (go && fd |=> $stable(acc_o))
        else $error("file destination moved acc");
    chk_zero_acc: assert property (go && !fd |=> zero_o == (acc_o == 8'h00))
        else $error("zero flag wrong");
    chk_refused_idle: assert property (!go |=> !done_o && $stable(acc_o) && $stable(zero_o))
        else $error("ignored word acted");
    chk_op_inc: assert property (go && opc == 6'h0a |=> done_o && op_o == 4'b0010)
        else $error("increment class wrong");
    chk_op_or: assert property (go && opc inside {6'h38, 6'h04}
        |=> done_o && op_o == 4'b0100) else $error("OR class wrong");
    chk_op_move: assert property (go && opc == 6'h08 |=> done_o && op_o == 4'b1000)
        else $error("move class wrong");
    chk_or_keeps: assert property (go && opc == 6'h04 && !fd
        |=> (acc_o & $past(acc_o)) == $past(acc_o)) else $error("OR lost acc bits");
endmodule : iom_exec_checker
bind iom_exec iom_exec_checker #(.FILE_WORDS(FILE_WORDS)) u_chk (.ref_clk_i, .rst_n_i,
    .instr_next_i, .instr_valid_i, .instr_i, .acc_o, .zero_o, .done_o, .op_o);

// ==== tb/tb_incr_or_move_exec.sv ====
/* Random self-checking bench with a reference model. Assumes file memory starts unknown. */
`timescale 1ns/1ps
module tb_incr_or_move_exec;
    logic ref_clk_i = 0, rst_n_i = 0, instr_valid_i = 0, zero_o, done_o;
    logic [13:0] instr_next_i = '0, instr_i = '0;
    logic [7:0] acc_o;
    logic [3:0] op_o;
    logic [5:0] opt [5] = '{6'h0a, 6'h38, 6'h04, 6'h08, 6'h3c};
    logic [14:0] prog [$];
    int error_cnt = 0, checks_done = 0, seed = 82, n, acc = 0, zf = 0, dn = 0, op = 1;
    int mem [128];
    always #20 ref_clk_i = ~ref_clk_i;
    iom_exec u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .instr_next_i(instr_next_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i), .acc_o(acc_o), .zero_o(zero_o),
        .done_o(done_o), .op_o(op_o));
    task automatic cmp(input string nm, input logic [7:0] got, input int exp);
        checks_done++;
        if (got !== exp[7:0]) begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", nm, exp[7:0], got);
        end
    endtask : cmp
    task automatic step(input logic [13:0] w, input bit v);
        int f, r;
        f = mem[w[6:0]];
        dn = 0;
        op = 1;
        if (v && w[13:8] inside {6'h0a, 6'h38, 6'h04, 6'h08}) begin
            dn = 1;
            r = w[13:8] == 6'h0a ? (f + 1) % 256 : w[13:8] == 6'h08 ? f :
                w[13:8] == 6'h04 ? (acc | f) : (acc | w[7:0]);
            op = w[13:8] == 6'h0a ? 2 : w[13:8] == 6'h08 ? 8 : 4;
            zf = (r == 0);
            if (w[7] && w[13:8] != 6'h38) mem[w[6:0]] = r;
            else acc = r;
        end
    endtask : step
    task automatic finish_test();
        if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    initial begin
        // With acc all ones, OR into each file gives a known 0xff even over unknown cells.
        prog.push_back(15'h78ff);
        for (int a = 0; a < 128; a++) prog.push_back({1'b1, 6'h04, 1'b1, 7'(a)});
        for (int i = 0; i < 600; i++) begin
            n = $random(seed);
            prog.push_back({n[30:28] != 0, opt[n[7:0] % 5], n[23:16]});
        end
        instr_next_i = prog[0][13:0];
        repeat (20) @(negedge ref_clk_i);
        rst_n_i = 1;
        cmp("acc", acc_o, 0);
        cmp("op", op_o, 1);
        cmp("zero", zero_o, 0);
        cmp("done", done_o, 0);
        for (int i = 0; i < prog.size(); i++) begin
            instr_i = prog[i][13:0];
            instr_valid_i = prog[i][14];
            instr_next_i = i + 1 < prog.size() ? prog[i + 1][13:0] : '0;
            step(prog[i][13:0], prog[i][14]);
            @(negedge ref_clk_i);
            cmp("acc", acc_o, acc);
            cmp("zero", zero_o, zf);
            cmp("done", done_o, dn);
            cmp("op", op_o, op);
        end
        finish_test();
    end
    initial begin
        #200us;
        error_cnt++;
        finish_test();
    end
endmodule : tb_incr_or_move_exec
